// File: rtl/spc_pkg.sv
// package for serial port mode and infrared configuration block
package spc_pkg;
  // register byte addresses (each register one aligned 32-bit word)
  localparam logic [7:0] OFS_ONE_MODE = 8'h00;
  localparam logic [7:0] OFS_TWO_MODE = 8'h04;
  localparam logic [7:0] OFS_IR_OPT = 8'h08;
  localparam logic [7:0] OFS_IR_TMO = 8'h0C;
  localparam logic [7:0] OFS_IR_STAT = 8'h10;
  // printed register indices within each logical device
  localparam logic [7:0] IDX_MODE = 8'hF0;
  localparam logic [7:0] IDX_IR_OPT = 8'hF1;
  localparam logic [7:0] IDX_IR_TMO = 8'hF2;
  // reset values
  localparam logic [7:0] RST_ONE_MODE = 8'h00;
  localparam logic [7:0] RST_TWO_MODE = 8'h00;
  localparam logic [7:0] RST_IR_OPT = 8'h02;
  localparam logic [7:0] RST_IR_TMO = 8'h03;
  // field positions
  localparam int BIT_MIDI = 0;
  localparam int BIT_HS = 1;
  localparam int BIT_SHARE = 7;
  localparam int BIT_RX_POL = 0;
  localparam int BIT_TX_POL = 1;
  localparam int BIT_HALF = 2;
  localparam int IRM_LO = 3;
  localparam int IRM_HI = 5;
  // writable masks (reserved bits read zero)
  localparam logic [7:0] MASK_ONE_MODE = 8'h83;
  localparam logic [7:0] MASK_TWO_MODE = 8'h03;
  localparam logic [7:0] MASK_IR_OPT = 8'h3F;
  // infrared mode codes
  typedef enum logic [2:0] {
    IRM_STANDARD = 3'b000,
    IRM_AMPLITUDE_SHIFT = 3'b010,
    IRM_IRDA = 3'b011
  } spc_ir_mode_t;
  // timing
  localparam int CLK_MHZ = 200;
  localparam int STEP_US = 100;
  localparam int STEP_CYC = STEP_US * CLK_MHZ;
  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : spc_pkg

// File: rtl/spc_serial_cfg.sv
// serial port mode registers, interrupt sharing and infrared half duplex blanking
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/100ps

// Notes on behaviour
// [RULE_01] mode bit 0 enables midi support
// [RULE_02] mode bit 1 enables high speed
// [RULE_03] port one bit 7 shares interrupt
// [RULE_04] software writes zero to reserved mode bits
// [RULE_05] software assigns pins before setting sharing
// [RULE_06] sharing drives both interrupt outputs together
// [RULE_07] option bit 0 inverts receive input
// [RULE_08] option bit 1 inverts transmit, default low
// [RULE_09] option bit 2 selects half duplex
// [RULE_10] option bits 5:3 select port function
// [RULE_11] software writes zero to option bits 7:6
// [RULE_12] timeout counts 100 us steps up to 10 ms; the code accepts any 8-bit count, up to 255 steps (25.5 ms)
// [RULE_13] zero blanks only during activity
// [RULE_14] any reset source loads register defaults
// [RULE_15] half duplex blanks opposite direction
module spc_serial_cfg
  import spc_pkg::*;
#(
  parameter int STEP_CYCLES = STEP_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // extra reset sources, synchronous active high
  input wire logic vtr_por,
  input wire logic hard_reset,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // uart core interrupt requests
  input wire logic first_serial_port_irq,
  input wire logic second_serial_port_irq,
  output logic first_serial_port_irq_out,
  output logic second_serial_port_irq_out,
  // mode outputs
  output logic first_serial_port_midi,
  output logic first_serial_port_high_speed,
  output logic second_serial_port_midi,
  output logic second_serial_port_high_speed,
  output logic [2:0] ir_mode,
  // infrared line side
  input wire logic ir_rx_pin,
  output logic ir_tx_pin,
  // second uart core side
  input wire logic core_tx_data,
  input wire logic core_tx_active,
  output logic core_rx_data,
  output logic core_rx_active
);

  logic rst;
  assign rst = !aresetn || vtr_por || hard_reset;

  logic [7:0] one_mode_q;
  logic [7:0] two_mode_q;
  logic [7:0] ir_opt_q;
  logic [7:0] ir_tmo_q;

  // write channel capture
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wstrb0_q;
  logic do_write;
  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (rst) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb0_q <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
    end
  end

  function automatic logic addr_known(input logic [7:0] a);
    return a == OFS_ONE_MODE || a == OFS_TWO_MODE || a == OFS_IR_OPT || a == OFS_IR_TMO || a == OFS_IR_STAT;
  endfunction : addr_known

  always_ff @(posedge aclk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= addr_known(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // [RULE_14] defaults on every reset source
  always_ff @(posedge aclk) begin
    if (rst) begin
      one_mode_q <= RST_ONE_MODE;
      two_mode_q <= RST_TWO_MODE;
      ir_opt_q <= RST_IR_OPT;
      ir_tmo_q <= RST_IR_TMO;
    end else if (do_write && wstrb0_q) begin
      unique case (awaddr_q)
        OFS_ONE_MODE: one_mode_q <= wdata_q[7:0] & MASK_ONE_MODE;
        OFS_TWO_MODE: two_mode_q <= wdata_q[7:0] & MASK_TWO_MODE;
        OFS_IR_OPT: ir_opt_q <= wdata_q[7:0] & MASK_IR_OPT;
        OFS_IR_TMO: ir_tmo_q <= wdata_q[7:0];
        default: ;
      endcase
    end
  end

  // read channel
  logic blank_rx;
  logic blank_tx;
  always_ff @(posedge aclk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_rvalid) begin
      s_axi_arready <= 1'b0;
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        OFS_ONE_MODE: s_axi_rdata <= {24'h00_0000, one_mode_q};
        OFS_TWO_MODE: s_axi_rdata <= {24'h00_0000, two_mode_q};
        OFS_IR_OPT: s_axi_rdata <= {24'h00_0000, ir_opt_q};
        OFS_IR_TMO: s_axi_rdata <= {24'h00_0000, ir_tmo_q};
        OFS_IR_STAT: s_axi_rdata <= {30'h0000_0000, blank_tx, blank_rx};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // [RULE_01] [RULE_02] mode outputs
  always_ff @(posedge aclk) begin
    if (rst) begin
      first_serial_port_midi <= 1'b0;
      first_serial_port_high_speed <= 1'b0;
      second_serial_port_midi <= 1'b0;
      second_serial_port_high_speed <= 1'b0;
      ir_mode <= IRM_STANDARD;
    end else begin
      first_serial_port_midi <= one_mode_q[BIT_MIDI];
      first_serial_port_high_speed <= one_mode_q[BIT_HS];
      second_serial_port_midi <= two_mode_q[BIT_MIDI];
      second_serial_port_high_speed <= two_mode_q[BIT_HS];
      // [RULE_10] port function select
      ir_mode <= ir_opt_q[IRM_HI:IRM_LO];
    end
  end

  // [RULE_03] [RULE_06] interrupt sharing
  always_ff @(posedge aclk) begin
    if (rst) begin
      first_serial_port_irq_out <= 1'b0;
      second_serial_port_irq_out <= 1'b0;
    end else if (one_mode_q[BIT_SHARE]) begin
      first_serial_port_irq_out <= first_serial_port_irq || second_serial_port_irq;
      second_serial_port_irq_out <= first_serial_port_irq || second_serial_port_irq;
    end else begin
      first_serial_port_irq_out <= first_serial_port_irq;
      second_serial_port_irq_out <= second_serial_port_irq;
    end
  end

  // receive pin synchroniser
  logic rx_meta_q;
  logic rx_sync_q;
  always_ff @(posedge aclk) begin
    if (rst) begin
      rx_meta_q <= 1'b0;
      rx_sync_q <= 1'b0;
    end else begin
      rx_meta_q <= ir_rx_pin;
      rx_sync_q <= rx_meta_q;
    end
  end

  // [RULE_07] receive polarity to active high
  logic rx_level;
  assign rx_level = rx_sync_q ^ ir_opt_q[BIT_RX_POL];

  // [RULE_12] [RULE_13] hold timers after activity
  logic [7:0] tx_steps_q;
  logic [7:0] rx_steps_q;
  logic [$clog2(STEP_CYCLES+1)-1:0] tx_cyc_q;
  logic [$clog2(STEP_CYCLES+1)-1:0] rx_cyc_q;
  localparam logic [$clog2(STEP_CYCLES+1)-1:0] STEP_LAST = ($clog2(STEP_CYCLES+1))'(STEP_CYCLES - 1);

  always_ff @(posedge aclk) begin
    if (rst || core_tx_active) begin
      tx_steps_q <= rst ? 8'h00 : ir_tmo_q;
      tx_cyc_q <= '0;
    end else if (tx_steps_q != 8'h00) begin
      if (tx_cyc_q == STEP_LAST) begin
        tx_cyc_q <= '0;
        tx_steps_q <= tx_steps_q - 8'h01;
      end else begin
        tx_cyc_q <= tx_cyc_q + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (rst || rx_level) begin
      rx_steps_q <= rst ? 8'h00 : ir_tmo_q;
      rx_cyc_q <= '0;
    end else if (rx_steps_q != 8'h00) begin
      if (rx_cyc_q == STEP_LAST) begin
        rx_cyc_q <= '0;
        rx_steps_q <= rx_steps_q - 8'h01;
      end else begin
        rx_cyc_q <= rx_cyc_q + 1'b1;
      end
    end
  end

  // [RULE_09] [RULE_15] half duplex blanking
  assign blank_rx = ir_opt_q[BIT_HALF] && (core_tx_active || tx_steps_q != 8'h00);
  assign blank_tx = ir_opt_q[BIT_HALF] && !blank_rx && (rx_level || rx_steps_q != 8'h00);

  // [RULE_08] transmit polarity, idle is inactive level
  always_ff @(posedge aclk) begin
    if (rst) begin
      ir_tx_pin <= RST_IR_OPT[BIT_TX_POL];
      core_rx_data <= 1'b0;
      core_rx_active <= 1'b0;
    end else begin
      ir_tx_pin <= (core_tx_data && !blank_tx) ^ ir_opt_q[BIT_TX_POL];
      core_rx_data <= rx_level && !blank_rx;
      core_rx_active <= blank_rx;
    end
  end

  // [RULE_06]
  chk_share_both_irq: assert property (@(posedge aclk) disable iff (rst) // [RULE_06]
    !rst && one_mode_q[BIT_SHARE] && (first_serial_port_irq || second_serial_port_irq)
    |=> first_serial_port_irq_out && second_serial_port_irq_out)
    else $error("shared interrupt not on both outputs");
  // [RULE_03]
  chk_own_irq_line: assert property (@(posedge aclk) disable iff (rst) // [RULE_03]
    !rst && !one_mode_q[BIT_SHARE] |=> second_serial_port_irq_out == $past(second_serial_port_irq))
    else $error("unshared interrupt not passed through");
  // [RULE_01]
  chk_midi_follow: assert property (@(posedge aclk) disable iff (rst) // [RULE_01]
    !rst |=> first_serial_port_midi == $past(one_mode_q[BIT_MIDI])
      && second_serial_port_midi == $past(two_mode_q[BIT_MIDI]))
    else $error("midi output mismatch");
  // [RULE_02]
  chk_hs_follow: assert property (@(posedge aclk) disable iff (rst) // [RULE_02]
    !rst |=> first_serial_port_high_speed == $past(one_mode_q[BIT_HS])
      && second_serial_port_high_speed == $past(two_mode_q[BIT_HS]))
    else $error("high speed output mismatch");
  // [RULE_14]
  chk_reset_values: assert property (@(posedge aclk) // [RULE_14]
    rst |=> ir_opt_q == RST_IR_OPT && ir_tmo_q == RST_IR_TMO && one_mode_q == RST_ONE_MODE
      && two_mode_q == RST_TWO_MODE)
    else $error("reset defaults wrong");
  // [RULE_10]
  chk_ir_mode: assert property (@(posedge aclk) disable iff (rst) // [RULE_10]
    !rst |=> ir_mode == $past(ir_opt_q[IRM_HI:IRM_LO]))
    else $error("ir mode output mismatch");
  // [RULE_09]
  chk_full_no_blank: assert property (@(posedge aclk) disable iff (rst) // [RULE_09]
    !ir_opt_q[BIT_HALF] |-> !blank_rx && !blank_tx)
    else $error("blanking in full duplex");
  // [RULE_13]
  chk_zero_tmo: assert property (@(posedge aclk) disable iff (rst) // [RULE_13]
    ir_tmo_q == 8'h00 && $fell(core_tx_active) |=> tx_steps_q == 8'h00)
    else $error("zero timeout extended blanking");
  // [RULE_15]
  chk_rx_blank: assert property (@(posedge aclk) disable iff (rst) // [RULE_15]
    ir_opt_q[BIT_HALF] && core_tx_active |=> !core_rx_data)
    else $error("receive not blanked while sending");
  // [RULE_08]
  chk_tx_polarity: assert property (@(posedge aclk) disable iff (rst) // [RULE_08]
    !rst && !core_tx_data |=> ir_tx_pin == $past(ir_opt_q[BIT_TX_POL]))
    else $error("idle transmit level wrong");
  // [RULE_09]
  chk_full_tx_pass: assert property (@(posedge aclk) disable iff (rst) // [RULE_09]
    !rst && !ir_opt_q[BIT_HALF] |=> ir_tx_pin == ($past(core_tx_data) ^ $past(ir_opt_q[BIT_TX_POL])))
    else $error("full duplex transmit blocked");
  // [RULE_13]
  chk_hold_after_tx: assert property (@(posedge aclk) disable iff (rst) // [RULE_13]
    !$past(rst) && ir_opt_q[BIT_HALF] && $past(ir_tmo_q) != 8'h00 && $fell(core_tx_active) |-> blank_rx)
    else $error("no receive blanking after transmit");
  // [RULE_15]
  chk_tx_blank_idle: assert property (@(posedge aclk) disable iff (rst) // [RULE_15]
    !rst && blank_tx |=> ir_tx_pin == $past(ir_opt_q[BIT_TX_POL]))
    else $error("transmit not blanked after receive");

  cov_share: cover property (@(posedge aclk) disable iff (rst) one_mode_q[BIT_SHARE] && first_serial_port_irq);
  cov_half_rx_blank: cover property (@(posedge aclk) disable iff (rst) blank_rx && rx_level);
  cov_half_tx_blank: cover property (@(posedge aclk) disable iff (rst) blank_tx && core_tx_data);
  cov_write_ack: cover property (@(posedge aclk) disable iff (rst) s_axi_bvalid && s_axi_bready);

endmodule : spc_serial_cfg

// File: bench/spc_ir_xcvr.sv
// infrared transceiver model with optical echo of its own transmitter
`timescale 1ns/100ps
module spc_ir_xcvr (
  // clock
  input wire logic aclk,
  // bench controls
  input wire logic light_on,
  input wire logic rx_low,
  input wire logic tx_low,
  // line side
  input wire logic ir_tx_pin,
  output logic ir_rx_pin
);
  // own emission leaks back into the receiver, as real parts do
  always @(posedge aclk) begin
    ir_rx_pin <= (light_on | (ir_tx_pin ^ tx_low)) ^ rx_low;
  end
endmodule : spc_ir_xcvr

// File: bench/spc_serial_cfg_tb.sv
// self-checking bench for the serial mode and infrared configuration block
`timescale 1ns/100ps
module spc_serial_cfg_tb;
  import spc_pkg::*;
  localparam int STEP = 4;
  logic aclk = 0, aresetn = 0, vtr_por = 0, hard_reset = 0;
  logic [7:0] awaddr = 0, araddr = 0, r;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, arready, bvalid, rvalid;
  logic [1:0] bresp, rresp;
  logic irq1 = 0, irq2 = 0, irq1_out, irq2_out, midi1, hs1, midi2, hs2;
  logic [2:0] ir_mode;
  logic rx_pin, tx_pin, tx_data = 0, tx_act = 0, rx_data, rx_act, light = 0, inv = 0;
  logic [33:0] exp_q[$];
  spc_ir_mode_t modes[3] = '{IRM_STANDARD, IRM_AMPLITUDE_SHIFT, IRM_IRDA};
  int n_errors = 0, checked = 0, seed = 1559;

  always #2.5 aclk = ~aclk;

  spc_serial_cfg #(.STEP_CYCLES(STEP)) dut (
    .aclk(aclk), .aresetn(aresetn), .vtr_por(vtr_por), .hard_reset(hard_reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .first_serial_port_irq(irq1), .second_serial_port_irq(irq2),
    .first_serial_port_irq_out(irq1_out), .second_serial_port_irq_out(irq2_out),
    .first_serial_port_midi(midi1), .first_serial_port_high_speed(hs1),
    .second_serial_port_midi(midi2), .second_serial_port_high_speed(hs2),
    .ir_mode(ir_mode), .ir_rx_pin(rx_pin), .ir_tx_pin(tx_pin),
    .core_tx_data(tx_data), .core_tx_active(tx_act), .core_rx_data(rx_data), .core_rx_active(rx_act)
  );

  spc_ir_xcvr xcvr (
    .aclk(aclk), .light_on(light), .rx_low(inv), .tx_low(1'b0), .ir_tx_pin(tx_pin), .ir_rx_pin(rx_pin)
  );

  task check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  task hang(input int i);
    if (i >= 200) begin
      n_errors++;
      $display("MISMATCH handshake expected answer seen none");
      report_and_stop();
    end
  endtask : hang

  task tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] resp);
    int i;
    @(posedge aclk);
    exp_q.push_back({resp, 32'h0000_0000});
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    hang(i);
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] resp);
    int i;
    @(posedge aclk);
    exp_q.push_back({resp, 24'h00_0000, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    hang(i);
  endtask : rd

  // answers are matched against the oldest note
  always @(posedge aclk) begin
    if (bvalid && bready) check("bresp", {bresp, 32'h0000_0000}, exp_q.pop_front());
    if (rvalid && rready) check("rdata", {rresp, rdata}, exp_q.pop_front());
  end

  initial begin
    tick(5);
    aresetn <= 1'b1;
    check("tx idle", tx_pin, 1'b1);
    rd(OFS_ONE_MODE, RST_ONE_MODE, RESP_OKAY);
    rd(OFS_TWO_MODE, RST_TWO_MODE, RESP_OKAY);
    rd(OFS_IR_OPT, RST_IR_OPT, RESP_OKAY);
    rd(OFS_IR_TMO, RST_IR_TMO, RESP_OKAY);
    rd(8'h14, 8'h00, RESP_SLVERR);
    wr(8'h14, 8'h55, RESP_SLVERR);
    $display("test reset values done");
    for (int k = 0; k < 8; k++) begin
      r = 8'($random(seed));
      wr(OFS_ONE_MODE, r & MASK_ONE_MODE, RESP_OKAY);
      rd(OFS_ONE_MODE, r & MASK_ONE_MODE, RESP_OKAY);
      wr(OFS_TWO_MODE, ~r & MASK_TWO_MODE, RESP_OKAY);
      rd(OFS_TWO_MODE, ~r & MASK_TWO_MODE, RESP_OKAY);
      tick(2);
      check("mode outs", {midi1, hs1, midi2, hs2}, {r[0], r[1], ~r[0], ~r[1]});
    end
    $display("test mode bits done");
    for (int k = 0; k < 3; k++) begin
      wr(OFS_IR_OPT, {2'b00, modes[k], 3'b010}, RESP_OKAY);
      rd(OFS_IR_OPT, {2'b00, modes[k], 3'b010}, RESP_OKAY);
      tick(2);
      check("ir mode", ir_mode, modes[k]);
    end
    tx_data <= 1'b1;
    tick(3);
    check("tx active low", tx_pin, 1'b0);
    tx_data <= 1'b0;
    $display("test infrared modes done");
    wr(OFS_ONE_MODE, 8'h00, RESP_OKAY);
    irq1 <= 1'b1;
    tick(3);
    check("irq separate", {irq1_out, irq2_out}, 2'b10);
    wr(OFS_ONE_MODE, 8'h80, RESP_OKAY);
    tick(2);
    check("irq shared one", {irq1_out, irq2_out}, 2'b11);
    irq1 <= 1'b0;
    irq2 <= 1'b1;
    tick(3);
    check("irq shared two", {irq1_out, irq2_out}, 2'b11);
    irq2 <= 1'b0;
    tick(3);
    check("irq quiet", {irq1_out, irq2_out}, 2'b00);
    $display("test interrupt sharing done");
    wr(OFS_IR_OPT, 8'h01, RESP_OKAY);
    light <= 1'b1;
    inv <= 1'b1;
    tick(6);
    check("rx active low", rx_data, 1'b1);
    tx_data <= 1'b1;
    tx_act <= 1'b1;
    tick(4);
    check("tx active high", tx_pin, 1'b1);
    check("full duplex", rx_act, 1'b0);
    tx_data <= 1'b0;
    tx_act <= 1'b0;
    light <= 1'b0;
    tick(6);
    $display("test polarity done");
    for (int t = 3; t >= 0; t -= 3) begin
      wr(OFS_IR_OPT, 8'h05, RESP_OKAY);
      wr(OFS_IR_TMO, 8'(t), RESP_OKAY);
      tx_data <= 1'b1;
      tx_act <= 1'b1;
      tick(8);
      check("rx blanked", {rx_act, rx_data}, 2'b10);
      tx_data <= 1'b0;
      tx_act <= 1'b0;
      tick(4);
      check("blank hold", rx_act, t != 0);
      if (t > 0) tick(t * STEP - 4);
      check("blank last step", rx_act, t != 0);
      tick(2);
      check("blank end", rx_act, 1'b0);
    end
    $display("test half duplex done");
    for (int s = 0; s < 2; s++) begin
      wr(OFS_IR_TMO, 8'h2a, RESP_OKAY);
      if (s == 0) hard_reset <= 1'b1;
      else vtr_por <= 1'b1;
      tick(1);
      hard_reset <= 1'b0;
      vtr_por <= 1'b0;
      rd(OFS_IR_TMO, RST_IR_TMO, RESP_OKAY);
      rd(OFS_IR_OPT, RST_IR_OPT, RESP_OKAY);
    end
    $display("test reset sources done");
    report_and_stop();
  end
endmodule : spc_serial_cfg_tb
